/* File: core/cgl_pkg.sv */
package cgl_pkg;

   // Register indices, used on the configuration write and read port.
   localparam logic [3:0] IDX_TOP_CONTROL    = 4'h0;
   localparam logic [3:0] IDX_SEQ_CONTROL    = 4'h1;
   localparam logic [3:0] IDX_T0_CTRL_FIRST  = 4'h5;
   localparam logic [3:0] IDX_T0_CTRL_SECOND = 4'h6;
   localparam logic [3:0] IDX_T0_CTRL_THIRD  = 4'h7;
   localparam logic [3:0] IDX_T0_PATTERN     = 4'h8;
   localparam logic [3:0] IDX_T1_CTRL_FIRST  = 4'h9;
   localparam logic [3:0] IDX_T1_CTRL_SECOND = 4'hA;
   localparam logic [3:0] IDX_T1_CTRL_THIRD  = 4'hB;
   localparam logic [3:0] IDX_T1_PATTERN     = 4'hC;
   localparam logic [3:0] IDX_TABLE_STRIDE   = 4'h4;

   // Field positions.
   localparam int TOP_ENABLE_BIT   = 0;
   localparam int TOP_STANDBY_BIT  = 6;
   localparam int CF_ENABLE_BIT    = 0;
   localparam int CF_OUTEN_BIT     = 3;
   localparam int CF_FILT_LSB      = 4;
   localparam int CF_CLOCK_SOURCE_SELECT_BIT    = 6;
   localparam int CF_EDGE_BIT      = 7;
   localparam int SEL_ZERO_LSB     = 0;
   localparam int SEL_ONE_LSB      = 4;

   // Writable bit masks; the other bits read as zero.
   localparam logic [7:0] TOP_CONTROL_MASK = 8'h41;
   localparam logic [7:0] CTRL_FIRST_MASK  = 8'hF9;
   localparam logic [7:0] CTRL_THIRD_MASK  = 8'h0F;
   localparam logic [7:0] SEQ_CONTROL_MASK = 8'h0F;

   // Reset values.
   localparam logic [7:0] RESET_BYTE       = 8'h00;

   typedef enum logic [3:0] {
      SRC_MASKED     = 4'h0,
      SRC_FEEDBACK   = 4'h1,
      SRC_LINK       = 4'h2,
      SRC_EVENT_ZERO = 4'h3,
      SRC_EVENT_ONE  = 4'h4,
      SRC_PIN        = 4'h5,
      SRC_COMPARATOR = 4'h6,
      SRC_TIMER_A    = 4'h7,
      SRC_TIMER_B    = 4'h8
   } cgl_src_t;

   typedef enum logic [3:0] {
      SEQ_OFF    = 4'h0,
      SEQ_DFF    = 4'h1,
      SEQ_JK     = 4'h2,
      SEQ_DLATCH = 4'h3,
      SEQ_RS     = 4'h4
   } cgl_seq_t;

   typedef enum logic [1:0] {
      FILT_NONE   = 2'h0,
      FILT_SYNC   = 2'h1,
      FILT_FILTER = 2'h2,
      FILT_RSVD   = 2'h3
   } cgl_filt_t;

endpackage : cgl_pkg

/* File: core/cgl_table.sv */
`timescale 1ns/1ps
module cgl_table
   import cgl_pkg::*;
(
   input  wire logic       clk_sys,         // Peripheral clock.
   input  wire logic       sys_rst,         // Synchronous reset, active high.
   input  wire logic       tableOn,         // Table and block both enabled.
   input  wire logic [7:0] patternReg,      // Lookup pattern.
   input  wire logic       clockFromLine2,  // Clock taken from input line two.
   input  wire logic [1:0] filterMode,      // Output filter option.
   input  wire logic       edgeEnable,      // Rising edge detector on.
   input  wire logic [2:0] lineIn,          // Selected input lines.
   output logic            directOut,       // Pattern output before filtering.
   output logic            tableOut,        // Output after filter and edge stage.
   output logic            clockTick        // One cycle per selected clock edge.
);

   logic       line2Prev_reg;
   logic       syncA_reg;
   logic       syncB_reg;
   logic       syncC_reg;
   logic       filt_reg;
   logic       edgePrev_reg;
   logic [2:0] lookIdx;
   logic       samplesAgree;
   logic       stageOut;
   cgl_filt_t  filtSel;

   assign filtSel = cgl_filt_t'(filterMode);

   // The line two clock is sampled as a plain input; its rising edge becomes a tick.
   // RL9: selected clock
   assign clockTick = clockFromLine2 ? (lineIn[2] & ~line2Prev_reg) : 1'b1;

   // RL24: line two masked
   // RL2: pattern index
   assign lookIdx   = {lineIn[2] & ~clockFromLine2, lineIn[1], lineIn[0]};
   // RL25: disabled low
   assign directOut = tableOn & patternReg[lookIdx];

   assign samplesAgree = (syncA_reg == syncB_reg) && (syncB_reg == syncC_reg);

   // RL21: filter delay
   assign stageOut = (filtSel == FILT_SYNC)   ? syncB_reg :
                     (filtSel == FILT_FILTER) ? filt_reg  : directOut;

   // RL22: rising pulse
   assign tableOut = tableOn & (edgeEnable ? (stageOut & ~edgePrev_reg) : stageOut);

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         line2Prev_reg <= 1'b0;
      else
         line2Prev_reg <= lineIn[2];
   end

   // Stage logic is cleared on the edge after the table drops out.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !tableOn)
      begin
         syncA_reg    <= 1'b0;
         syncB_reg    <= 1'b0;
         syncC_reg    <= 1'b0;
         filt_reg     <= 1'b0;
         edgePrev_reg <= 1'b0;
      end
      else if (clockTick)
      begin
         syncA_reg    <= directOut;
         syncB_reg    <= syncA_reg;
         syncC_reg    <= syncB_reg;
         filt_reg     <= samplesAgree ? syncC_reg : filt_reg;
         edgePrev_reg <= stageOut;
      end
   end

endmodule : cgl_table

/* File: core/cgl_glue_logic.sv */
// Overview of operation
// RL1: Exactly two lookup tables, zero and one, each three inputs, pattern, output stage.
// RL2: Table output is the pattern bit indexed by inputs two, one, zero.
// RL3: An input selected as masked feeds logic low into the lookup.
// RL4: The global enable bit switches the whole block on and off.
// RL5: Each table has its own enable bit in its first control register.
// RL6: Sequencer function select accepts writes only while table zero is disabled.
// RL7: Table control fields other than enable accept writes only while disabled.
// RL8: Writing enable to one applies protected fields; clearing enable does not.
// RL9: Table logic uses peripheral clock, or input line two when selected.
// RL10: The sequential block runs on the clock chosen for table zero.
// RL11: Software clears the global enable before changing a clock source select.
// RL12: Feedback source feeds sequential block output to both tables.
// RL13: Link source feeds the next table's direct output; table one drives zero.
// RL14: Two event lines are selectable sources for any table input.
// RL15: Software routes events before choosing an event line as source.
// RL16: Pin source connects the dedicated input pin of that table and index.
// RL17: Inputs zero and one select in second control, input two in third.
// RL18: Comparator output and timer waveforms are also selectable sources.
// RL19: Each table output goes to an output pin and to the event system.
// RL20: The block keeps running while the processor is halted in debug.
// RL21: An enabled output filter delays the output two to five clocks.
// RL22: The edge detector emits one pulse on a rising lookup output.
// RL23: Sequential block is D flip-flop, JK, D latch or RS latch by select.
// RL24: With line two as clock, input two is masked low in the lookup.
// RL25: A disabled table, or one in a disabled block, drives low.
`timescale 1ns/1ps
module cgl_glue_logic
   import cgl_pkg::*;
(
   input  wire logic       clk_sys,          // Peripheral clock, 20 MHz.
   input  wire logic       sys_rst,          // Synchronous reset, active high.
   input  wire logic       cfgWrite,         // Configuration write strobe.
   input  wire logic [3:0] cfgIndex,         // Register index for write and read.
   input  wire logic [7:0] cfgWriteData,     // Write data.
   output logic      [7:0] cfgReadData,      // Registered read data of cfgIndex.
   input  wire logic [2:0] pinInZero,        // Input pins of table zero.
   input  wire logic [2:0] pinInOne,         // Input pins of table one.
   input  wire logic       eventLineZero,    // Event input line zero.
   input  wire logic       eventLineOne,     // Event input line one.
   input  wire logic       analogComparator, // Comparator output.
   input  wire logic [1:0] timerWaveform,    // Timer waveform outputs A and B.
   output logic      [1:0] tablePinOut,      // Table outputs toward the pins.
   output logic      [1:0] tablePinOutEn,    // Pin drive enables.
   output logic      [1:0] tableEventOut,    // Table outputs as event generators.
   output logic            sequentialOut,    // Sequential block output.
   output logic            blockEnabled,     // Global enable state.
   output logic      [1:0] tableEnabled      // Per-table running state.
);

   logic [7:0] topControl_reg;
   logic [7:0] topControl_next;
   logic [7:0] seqControl_reg;
   logic [7:0] seqControl_next;
   logic [7:0] ctrlFirst_reg  [2];
   logic [7:0] ctrlFirst_next [2];
   logic [7:0] ctrlSecond_reg [2];
   logic [7:0] ctrlSecond_next[2];
   logic [7:0] ctrlThird_reg  [2];
   logic [7:0] ctrlThird_next [2];
   logic [7:0] pattern_reg    [2];
   logic [7:0] pattern_next   [2];
   logic [7:0] readData_reg;
   logic [7:0] readMux;
   logic       seqState_reg;
   logic       seqState_next;

   logic       globalOn;
   logic       hitTop;
   logic       hitSeq;
   logic       seqWriteOpen;
   logic       seqTick;
   logic       seqD;
   logic       seqG;
   cgl_seq_t   seqMode;
   logic [1:0] tableOn;
   logic [1:0] directOut;
   logic [1:0] stageOut;
   logic [1:0] tick;
   logic [1:0] linkIn;
   logic [2:0] pinIn   [2];
   logic [2:0] lineIn  [2];

   // Selects one source for one input line of one table.
   function automatic logic pickSource(
      input logic [3:0] sel,
      input logic       pin,
      input logic       feedback,
      input logic       link,
      input logic       evZero,
      input logic       evOne,
      input logic       comparator,
      input logic [1:0] timer
   );
      logic picked;
      picked = 1'b0;
      case (cgl_src_t'(sel))
         // RL3: masked low
         SRC_MASKED:     picked = 1'b0;

         // RL12: feedback source
         SRC_FEEDBACK:   picked = feedback;

         // RL13: link source
         SRC_LINK:       picked = link;

         // RL14: event lines
         SRC_EVENT_ZERO: picked = evZero;
         SRC_EVENT_ONE:  picked = evOne;

         // RL16: pin source
         SRC_PIN:        picked = pin;

         // RL18: peripheral sources
         SRC_COMPARATOR: picked = comparator;
         SRC_TIMER_A:    picked = timer[0];
         SRC_TIMER_B:    picked = timer[1];
         default:        picked = 1'b0;
      endcase
      return picked;
   endfunction : pickSource

   // RL4: global enable
   assign globalOn     = topControl_reg[TOP_ENABLE_BIT];
   assign blockEnabled = globalOn;

   // RL6: sequencer protect
   assign seqWriteOpen = ~ctrlFirst_reg[0][CF_ENABLE_BIT];

   assign pinIn[0] = pinInZero;
   assign pinIn[1] = pinInOne;

   // The last table has no higher neighbour, so its link input reads low.
   // RL13: table one drives zero
   assign linkIn[0] = directOut[1];
   assign linkIn[1] = 1'b0;

   assign hitTop = cfgWrite && (cfgIndex == IDX_TOP_CONTROL);
   assign hitSeq = cfgWrite && (cfgIndex == IDX_SEQ_CONTROL);

   always_comb
   begin
      topControl_next = topControl_reg;
      seqControl_next = seqControl_reg;
      if (hitTop)
         topControl_next = cfgWriteData & TOP_CONTROL_MASK;
      // A refused sequencer write is simply dropped.
      if (hitSeq && seqWriteOpen)
         seqControl_next = cfgWriteData & SEQ_CONTROL_MASK;
   end

   // RL1: two tables
   for (genvar t = 0; t < 2; t++)
   begin : g_table
      localparam logic [3:0] BASE = IDX_T0_CTRL_FIRST + 4'(t) * IDX_TABLE_STRIDE;

      logic hitFirst;
      logic hitSecond;
      logic hitThird;
      logic hitPattern;
      logic protectOpen;

      assign hitFirst    = cfgWrite && (cfgIndex == BASE);
      assign hitSecond   = cfgWrite && (cfgIndex == BASE + 4'h1);
      assign hitThird    = cfgWrite && (cfgIndex == BASE + 4'h2);
      assign hitPattern  = cfgWrite && (cfgIndex == BASE + 4'h3);

      // RL7: enable protection
      assign protectOpen = ~ctrlFirst_reg[t][CF_ENABLE_BIT];

      always_comb
      begin
         ctrlFirst_next[t]  = ctrlFirst_reg[t];
         ctrlSecond_next[t] = ctrlSecond_reg[t];
         ctrlThird_next[t]  = ctrlThird_reg[t];
         pattern_next[t]    = pattern_reg[t];
         // From the disabled state a write takes every field at once.
         // RL8: enable with fields
         if (hitFirst && protectOpen)
            ctrlFirst_next[t] = cfgWriteData & CTRL_FIRST_MASK;
         // RL5: table enable
         else if (hitFirst)
            ctrlFirst_next[t][CF_ENABLE_BIT] = cfgWriteData[CF_ENABLE_BIT];
         // RL17: select fields
         if (hitSecond && protectOpen)
            ctrlSecond_next[t] = cfgWriteData;
         if (hitThird && protectOpen)
            ctrlThird_next[t] = cfgWriteData & CTRL_THIRD_MASK;
         // The pattern stays writable while the table runs.
         if (hitPattern)
            pattern_next[t] = cfgWriteData;
      end

      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
         begin
            ctrlFirst_reg[t]  <= RESET_BYTE;
            ctrlSecond_reg[t] <= RESET_BYTE;
            ctrlThird_reg[t]  <= RESET_BYTE;
            pattern_reg[t]    <= RESET_BYTE;
         end
         else
         begin
            ctrlFirst_reg[t]  <= ctrlFirst_next[t];
            ctrlSecond_reg[t] <= ctrlSecond_next[t];
            ctrlThird_reg[t]  <= ctrlThird_next[t];
            pattern_reg[t]    <= pattern_next[t];
         end
      end

      // RL25: disabled low
      assign tableOn[t] = globalOn & ctrlFirst_reg[t][CF_ENABLE_BIT];

      // RL17: three selects
      assign lineIn[t][0] = pickSource(ctrlSecond_reg[t][SEL_ZERO_LSB +: 4], pinIn[t][0], seqState_reg,
                                       linkIn[t], eventLineZero, eventLineOne, analogComparator,
                                       timerWaveform);
      assign lineIn[t][1] = pickSource(ctrlSecond_reg[t][SEL_ONE_LSB +: 4], pinIn[t][1], seqState_reg,
                                       linkIn[t], eventLineZero, eventLineOne, analogComparator,
                                       timerWaveform);
      assign lineIn[t][2] = pickSource(ctrlThird_reg[t][SEL_ZERO_LSB +: 4], pinIn[t][2], seqState_reg,
                                       linkIn[t], eventLineZero, eventLineOne, analogComparator,
                                       timerWaveform);

      cgl_table u_table (
         .clk_sys        (clk_sys),
         .sys_rst        (sys_rst),
         .tableOn        (tableOn[t]),
         .patternReg     (pattern_reg[t]),
         .clockFromLine2 (ctrlFirst_reg[t][CF_CLOCK_SOURCE_SELECT_BIT]),
         .filterMode     (ctrlFirst_reg[t][CF_FILT_LSB +: 2]),
         .edgeEnable     (ctrlFirst_reg[t][CF_EDGE_BIT]),
         .lineIn         (lineIn[t]),
         .directOut      (directOut[t]),
         .tableOut       (stageOut[t]),
         .clockTick      (tick[t])
      );

      // RL19: pin and event
      assign tablePinOut[t]   = stageOut[t];
      assign tablePinOutEn[t] = tableOn[t] & ctrlFirst_reg[t][CF_OUTEN_BIT];
      assign tableEventOut[t] = stageOut[t];
      assign tableEnabled[t]  = tableOn[t];
   end

   // RL10: even table clock
   assign seqTick = tick[0];
   assign seqD    = stageOut[0];
   assign seqG    = stageOut[1];
   assign seqMode = cgl_seq_t'(seqControl_reg[3:0]);

   // Latch modes are sampled on the selected clock too, which keeps the
   // feedback path free of a combinational loop at the cost of one clock.
   // RL23: sequential functions
   always_comb
   begin
      seqState_next = seqState_reg;

      case (seqMode)
         SEQ_OFF:    seqState_next = 1'b0;
         SEQ_DFF:    seqState_next = seqG ? seqD : seqState_reg;
         SEQ_JK:
         begin
            case ({seqD, seqG})
               2'b01:   seqState_next = 1'b0;
               2'b10:   seqState_next = 1'b1;
               2'b11:   seqState_next = ~seqState_reg;
               default: seqState_next = seqState_reg;
            endcase
         end
         SEQ_DLATCH: seqState_next = seqG ? seqD : seqState_reg;
         // RS with both inputs high is forbidden; it holds here.
         SEQ_RS:
         begin
            case ({seqD, seqG})
               2'b10:   seqState_next = 1'b1;
               2'b01:   seqState_next = 1'b0;
               default: seqState_next = seqState_reg;
            endcase
         end
         default:    seqState_next = 1'b0;
      endcase
   end

   // The sequential state clears one edge after table zero stops running.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !tableOn[0])
         seqState_reg <= 1'b0;
      else if (seqTick)
         seqState_reg <= seqState_next;
   end

   assign sequentialOut = seqState_reg;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         topControl_reg <= RESET_BYTE;
         seqControl_reg <= RESET_BYTE;
      end
      else
      begin
         topControl_reg <= topControl_next;
         seqControl_reg <= seqControl_next;
      end
   end

   // Unused indices read as zero, so probing the map is harmless.
   // There is no debug halt input: nothing here stops when the processor does.
   // RL20: runs in debug
   always_comb
   begin
      case (cfgIndex)
         IDX_TOP_CONTROL:    readMux = topControl_reg;
         IDX_SEQ_CONTROL:    readMux = seqControl_reg;
         IDX_T0_CTRL_FIRST:  readMux = ctrlFirst_reg[0];
         IDX_T0_CTRL_SECOND: readMux = ctrlSecond_reg[0];
         IDX_T0_CTRL_THIRD:  readMux = ctrlThird_reg[0];
         IDX_T0_PATTERN:     readMux = pattern_reg[0];
         IDX_T1_CTRL_FIRST:  readMux = ctrlFirst_reg[1];
         IDX_T1_CTRL_SECOND: readMux = ctrlSecond_reg[1];
         IDX_T1_CTRL_THIRD:  readMux = ctrlThird_reg[1];
         IDX_T1_PATTERN:     readMux = pattern_reg[1];
         default:            readMux = RESET_BYTE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         readData_reg <= RESET_BYTE;
      else
         readData_reg <= readMux;
   end

   assign cfgReadData = readData_reg;

endmodule : cgl_glue_logic

/* File: test/cgl_glue_logic_properties.sv */
`timescale 1ns/1ps
module cgl_glue_logic_checker
   import cgl_pkg::*;
(
   input wire logic       clk_sys,          // Clock.
   input wire logic       sys_rst,          // Reset.
   input wire logic       cfgWrite,         // Write strobe.
   input wire logic [3:0] cfgIndex,         // Index.
   input wire logic [7:0] cfgWriteData,     // Write data.
   input wire logic [7:0] cfgReadData,      // Read data.
   input wire logic [2:0] pinInZero,        // Pins zero.
   input wire logic [2:0] pinInOne,         // Pins one.
   input wire logic       eventLineZero,    // Event zero.
   input wire logic       eventLineOne,     // Event one.
   input wire logic       analogComparator, // Comparator.
   input wire logic [1:0] timerWaveform,    // Timer.
   input wire logic [1:0] tablePinOut,      // Pin outputs.
   input wire logic [1:0] tablePinOutEn,    // Pin enables.
   input wire logic [1:0] tableEventOut,    // Event outputs.
   input wire logic       sequentialOut,    // Sequential output.
   input wire logic       blockEnabled,     // Global enable.
   input wire logic [1:0] tableEnabled      // Table running.
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   pin_event_same_a: assert property (tablePinOut == tableEventOut)
      else $error("pin and event outputs differ");
   outen_needs_run_a: assert property ((tablePinOutEn & ~tableEnabled) == 2'b00)
      else $error("pin driven by stopped table");
   idle_table_low_a: assert property ((tablePinOut & ~tableEnabled) == 2'b00)
      else $error("stopped table output high");
   run_needs_global_a: assert property (tableEnabled != 2'b00 |-> blockEnabled)
      else $error("table runs in disabled block");
   global_write_a: assert property (cfgWrite && cfgIndex == IDX_TOP_CONTROL |=>
      blockEnabled == $past(cfgWriteData[TOP_ENABLE_BIT])) else $error("global enable not applied");
   table_enable_a: assert property (cfgWrite && cfgIndex == IDX_T0_CTRL_FIRST |=>
      tableEnabled[0] == ($past(cfgWriteData[CF_ENABLE_BIT]) && blockEnabled)) else $error("table enable wrong");
   unmapped_read_a: assert property (cfgIndex inside {4'h2, 4'h3, 4'h4, 4'hD, 4'hE, 4'hF} |=>
      cfgReadData == 8'h00) else $error("unmapped index read nonzero");
   top_readback_a: assert property (cfgIndex == IDX_TOP_CONTROL |=>
      cfgReadData[TOP_ENABLE_BIT] == $past(blockEnabled) && (cfgReadData & ~TOP_CONTROL_MASK) == 8'h00)
      else $error("top control readback wrong");
   seq_cleared_a: assert property (!tableEnabled[0] [*3] |-> !sequentialOut)
      else $error("sequential output kept while table zero stopped");
   cover property (cfgWrite && cfgIndex == IDX_SEQ_CONTROL);
   cover property ($rose(sequentialOut));
   cover property (tablePinOut == 2'b11);
endmodule : cgl_glue_logic_checker

bind cgl_glue_logic cgl_glue_logic_checker CHK (.clk_sys, .sys_rst, .cfgWrite, .cfgIndex, .cfgWriteData,
   .cfgReadData, .pinInZero, .pinInOne, .eventLineZero, .eventLineOne, .analogComparator, .timerWaveform,
   .tablePinOut, .tablePinOutEn, .tableEventOut, .sequentialOut, .blockEnabled, .tableEnabled);

/* File: test/cgl_partner_model.sv */
`timescale 1ns/1ps
module cgl_partner_model
(
   input  wire logic [11:0] stim,             // Levels asked by the bench.
   output logic      [2:0]  pinInZero,        // Pins of table zero.
   output logic      [2:0]  pinInOne,         // Pins of table one.
   output logic             eventLineZero,    // Event line zero.
   output logic             eventLineOne,     // Event line one.
   output logic             analogComparator, // Comparator level.
   output logic      [1:0]  timerWaveform     // Timer waveforms.
);
   assign pinInZero        = stim[2:0];
   assign pinInOne         = stim[5:3];
   // routing before use
   // Events come from a routing that is fixed before the bench selects them, so they are plain levels.
   assign eventLineZero    = stim[6];
   assign eventLineOne     = stim[7];
   assign analogComparator = stim[8];
   assign timerWaveform    = stim[10:9];
endmodule : cgl_partner_model

/* File: test/tb_cgl_glue_logic.sv */
`timescale 1ns/1ps
module tb_cgl_glue_logic;
   import cgl_pkg::*;
   logic        clk_sys      = 1'b0;
   logic        sys_rst      = 1'b1;
   logic        cfgWrite     = 1'b0;
   logic [3:0]  cfgIndex     = 4'h0;
   logic [7:0]  cfgWriteData = 8'h00;
   logic [11:0] stim         = 12'h000;
   logic [7:0]  cfgReadData;
   logic [2:0]  pinInZero, pinInOne;
   logic        eventLineZero, eventLineOne, analogComparator, sequentialOut, blockEnabled, e1, q;
   logic [1:0]  timerWaveform, tablePinOut, tablePinOutEn, tableEventOut, tableEnabled;
   logic [31:0] rng          = 32'h0B06;
   logic [7:0]  rv;
   logic [7:0]  pat [2];
   logic [11:0] sel [2];
   int          errCount     = 0;
   int          comparisons  = 0;
   int          n, t, k, f;

   cgl_partner_model PM (.stim, .pinInZero, .pinInOne, .eventLineZero, .eventLineOne, .analogComparator,
      .timerWaveform);
   cgl_glue_logic DUT (.clk_sys, .sys_rst, .cfgWrite, .cfgIndex, .cfgWriteData, .cfgReadData, .pinInZero,
      .pinInOne, .eventLineZero, .eventLineOne, .analogComparator, .timerWaveform, .tablePinOut,
      .tablePinOutEn, .tableEventOut, .sequentialOut, .blockEnabled, .tableEnabled);

   initial
   begin
      forever #25 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs

   // Feedback reads low because the sequencer stays off while these expectations are used.
   function automatic logic src(input logic [3:0] s, input logic p, input logic lnk);
      case (s)
         SRC_LINK:       return lnk;
         SRC_EVENT_ZERO: return eventLineZero;
         SRC_EVENT_ONE:  return eventLineOne;
         SRC_PIN:        return p;
         SRC_COMPARATOR: return analogComparator;
         SRC_TIMER_A:    return timerWaveform[0];
         SRC_TIMER_B:    return timerWaveform[1];
         default:        return 1'b0;
      endcase
   endfunction : src

   function automatic logic lut(input int tb, input logic lnk);
      logic [2:0] p;
      logic [2:0] ix;
      p = (tb == 1) ? pinInOne : pinInZero;
      for (int j = 0; j < 3; j++) ix[j] = src(sel[tb][4*j +: 4], p[j], lnk);
      return pat[tb][ix];
   endfunction : lut

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      @(posedge clk_sys);
      cfgWrite     <= 1'b1;
      cfgIndex     <= i;
      cfgWriteData <= d;
      @(posedge clk_sys);
      cfgWrite     <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] i, output logic [7:0] d);
      @(posedge clk_sys);
      cfgIndex <= i;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      d = cfgReadData;
   endtask : rd

   task results();
      $display("comparisons %0d errors %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errCount++;
      results();
   end

   initial
   begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      chk({sequentialOut, blockEnabled, tableEnabled, tablePinOut, tablePinOutEn}, 8'h00);
      for (n = 0; n < 16; n++)
      begin
         rd(4'(n), rv);
         chk(rv, RESET_BYTE);
      end
      wr(IDX_TOP_CONTROL, 8'h01);
      // Random selects include the unused codes above the timers, which must act as masked.
      repeat (12)
      begin
         for (t = 0; t < 2; t++)
         begin
            sel[t] = {4'(xs() % 11), 4'(xs() % 11), 4'(xs() % 11)};
            pat[t] = 8'(xs());
            wr(IDX_T0_CTRL_FIRST + 4'(t * 4), 8'h00);
            wr(IDX_T0_CTRL_SECOND + 4'(t * 4), sel[t][7:0]);
            wr(IDX_T0_CTRL_THIRD + 4'(t * 4), {4'h0, sel[t][11:8]});
            wr(IDX_T0_PATTERN + 4'(t * 4), pat[t]);
            wr(IDX_T0_CTRL_FIRST + 4'(t * 4), 8'h09);
         end
         repeat (8)
         begin
            @(posedge clk_sys);
            stim <= 12'(xs());
            @(negedge clk_sys);
            e1 = lut(1, 1'b0);
            chk(8'(tablePinOut[1]), 8'(e1));
            chk(8'(tablePinOut[0]), 8'(lut(0, e1)));
            chk(8'(tablePinOutEn), 8'h03);
         end
      end
      wr(IDX_T1_CTRL_SECOND, ~sel[1][7:0]);
      rd(IDX_T1_CTRL_SECOND, rv);
      chk(rv, sel[1][7:0]);
      wr(IDX_T1_CTRL_FIRST, 8'hF8);
      rd(IDX_T1_CTRL_FIRST, rv);
      chk(rv, 8'h08);
      wr(IDX_T1_CTRL_FIRST, 8'h19);
      rd(IDX_T1_CTRL_FIRST, rv);
      chk(rv, 8'h19);
      wr(IDX_SEQ_CONTROL, 8'h02);
      rd(IDX_SEQ_CONTROL, rv);
      chk(rv, 8'h00);
      wr(IDX_TOP_CONTROL, 8'h00);
      @(negedge clk_sys);
      chk({4'h0, tableEnabled, tablePinOut}, 8'h00);
      wr(IDX_T0_CTRL_FIRST, 8'h00);
      wr(IDX_SEQ_CONTROL, 8'h02);
      rd(IDX_SEQ_CONTROL, rv);
      chk(rv, 8'h02);
      wr(IDX_T0_CTRL_SECOND, 8'h05);
      wr(IDX_T0_CTRL_THIRD, 8'h05);
      wr(IDX_T0_PATTERN, 8'h02);
      wr(IDX_T0_CTRL_FIRST, 8'h49);
      wr(IDX_TOP_CONTROL, 8'h01);
      @(posedge clk_sys);
      stim <= 12'h005;
      @(negedge clk_sys);
      chk(8'(tablePinOut[0]), 8'h01);
      wr(IDX_TOP_CONTROL, 8'h00);
      wr(IDX_T0_CTRL_FIRST, 8'h00);
      wr(IDX_T0_CTRL_FIRST, 8'hA9);
      wr(IDX_TOP_CONTROL, 8'h01);
      @(posedge clk_sys);
      stim <= 12'h000;
      repeat (8) @(posedge clk_sys);
      stim <= 12'h001;
      k = 0;
      f = 0;
      for (n = 1; n <= 10; n++)
      begin
         @(negedge clk_sys);
         if (tablePinOut[0] === 1'b1)
         begin
            k++;
            if (f == 0) f = n;
         end
      end
      chk(8'(k), 8'h01);
      chk(8'(f >= 3 && f <= 6), 8'h01);
      wr(IDX_T0_CTRL_FIRST, 8'h00);
      wr(IDX_T0_PATTERN, 8'hFF);
      wr(IDX_T1_PATTERN, 8'hFF);
      wr(IDX_T0_CTRL_FIRST, 8'h09);
      repeat (8) @(negedge clk_sys);
      q = sequentialOut;
      k = 0;
      repeat (4)
      begin
         @(negedge clk_sys);
         if (sequentialOut !== q) k++;
         q = sequentialOut;
      end
      chk(8'(k), 8'h04);
      wr(IDX_T0_CTRL_FIRST, 8'h00);
      wr(IDX_SEQ_CONTROL, 8'h01);
      wr(IDX_T0_CTRL_FIRST, 8'h09);
      repeat (4) @(negedge clk_sys);
      chk(8'(sequentialOut), 8'h01);
      results();
   end
endmodule : tb_cgl_glue_logic
